// ==== common/asrc_pkg.sv ====
package asrc_pkg;
	localparam int ASRC_CLK_NS = 40;
	localparam int ASRC_AW = 15;
	localparam int ASRC_DW = 8;
	// Grade select: 0 = 55 ns part, 1 = 70 ns part
	localparam int ASRC_GRADE_FAST = 0;
	localparam int ASRC_GRADE_SLOW = 1;
	// Minimum times in ns, per grade
	localparam int ASRC_RC_NS_F = 55;
	localparam int ASRC_RC_NS_S = 70;
	localparam int ASRC_AA_NS_F = 55;
	localparam int ASRC_AA_NS_S = 70;
	localparam int ASRC_OE_NS_F = 25;
	localparam int ASRC_OE_NS_S = 35;
	localparam int ASRC_AW_NS_F = 45;
	localparam int ASRC_AW_NS_S = 60;
	localparam int ASRC_SD_NS_F = 25;
	localparam int ASRC_SD_NS_S = 30;
	localparam int ASRC_HZWE_NS_F = 20;
	localparam int ASRC_HZWE_NS_S = 25;
	localparam int ASRC_HZOE_NS_F = 20;
	localparam int ASRC_HZOE_NS_S = 25;
	localparam int ASRC_PWE_NS_F = 40;
	localparam int ASRC_PWE_NS_S = 50;
	localparam int ASRC_CNT_W = 4;
	localparam logic [ASRC_CNT_W-1:0] ASRC_CNT_ONE = 4'h1;

	// Round a least time up to whole cycles, never below one
	function automatic logic [ASRC_CNT_W-1:0] asrc_cyc(input int ns);
		int c;
		c = (ns + ASRC_CLK_NS - 1) / ASRC_CLK_NS;
		if (c < 1) c = 1;
		return c[ASRC_CNT_W-1:0];
	endfunction

	function automatic int asrc_sel(input int grade, input int f, input int s);
		return (grade == ASRC_GRADE_SLOW) ? s : f;
	endfunction

	typedef enum logic [2:0] {
		ASRC_IDLE = 3'b000,
		ASRC_RD_ACC = 3'b001,
		ASRC_RD_END = 3'b010,
		ASRC_WR_TURN = 3'b011,
		ASRC_WR_PULSE = 3'b100,
		ASRC_WR_END = 3'b101,
		ASRC_RECOVER = 3'b110
	} asrc_state_t;
endpackage

// ==== hw/asrc_sync.sv ====
module asrc_sync #(
	parameter int W = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	// Value accepted only once second and third stage agree
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			dout <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end
endmodule

// ==== hw/asrc_host.sv ====
// Functional notes
// - Write begins when both low; first to rise ends it.
// - Data setup and hold are timed to the ending rising edge.
// - Write data valid 25/30 ns before write end, held after.
// - Address stable 45/60 ns before write window ends.
// - Address changes only before write window opens.
// - Address held unchanged until write window has closed.
// - With output enable low, strobe pulse covers turnoff plus data setup.
// - Controller never drives bus while memory may still be driving.
// - Write strobe stays high throughout every read.
// - Address valid no later than select falling on reads.
module asrc_host #(
	parameter int GRADE = asrc_pkg::ASRC_GRADE_FAST
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [asrc_pkg::ASRC_AW-1:0] req_addr,
	input wire logic [asrc_pkg::ASRC_DW-1:0] req_wdata,
	output logic rsp_valid,
	output logic [asrc_pkg::ASRC_DW-1:0] rsp_rdata,
	output logic [asrc_pkg::ASRC_AW-1:0] word_address,
	output logic select_n,
	output logic out_enable_n,
	output logic write_strobe_n,
	input wire logic [asrc_pkg::ASRC_DW-1:0] shared_data_bus_in,
	output logic [asrc_pkg::ASRC_DW-1:0] shared_data_bus_out,
	output logic shared_data_bus_oe
);
	// Whole timing set follows the grade
	localparam logic [asrc_pkg::ASRC_CNT_W-1:0] RD_CYC = asrc_pkg::asrc_cyc(
		asrc_pkg::asrc_sel(GRADE, asrc_pkg::ASRC_AA_NS_F, asrc_pkg::ASRC_AA_NS_S));
	localparam logic [asrc_pkg::ASRC_CNT_W-1:0] OE_CYC = asrc_pkg::asrc_cyc(
		asrc_pkg::asrc_sel(GRADE, asrc_pkg::ASRC_OE_NS_F, asrc_pkg::ASRC_OE_NS_S));
	localparam logic [asrc_pkg::ASRC_CNT_W-1:0] HZOE_CYC = asrc_pkg::asrc_cyc(
		asrc_pkg::asrc_sel(GRADE, asrc_pkg::ASRC_HZOE_NS_F, asrc_pkg::ASRC_HZOE_NS_S));
	localparam logic [asrc_pkg::ASRC_CNT_W-1:0] HZWE_CYC = asrc_pkg::asrc_cyc(
		asrc_pkg::asrc_sel(GRADE, asrc_pkg::ASRC_HZWE_NS_F, asrc_pkg::ASRC_HZWE_NS_S));
	localparam int PWE_NS = asrc_pkg::asrc_sel(GRADE, asrc_pkg::ASRC_PWE_NS_F, asrc_pkg::ASRC_PWE_NS_S);
	localparam int AW_NS = asrc_pkg::asrc_sel(GRADE, asrc_pkg::ASRC_AW_NS_F, asrc_pkg::ASRC_AW_NS_S);
	localparam int SD_NS = asrc_pkg::asrc_sel(GRADE, asrc_pkg::ASRC_SD_NS_F, asrc_pkg::ASRC_SD_NS_S);
	localparam int HZWE_NS = asrc_pkg::asrc_sel(GRADE, asrc_pkg::ASRC_HZWE_NS_F, asrc_pkg::ASRC_HZWE_NS_S);
	// Pulse must cover pulse width, address window and turnoff plus setup
	localparam int WP_A = (PWE_NS > AW_NS) ? PWE_NS : AW_NS;
	localparam int WP_NS = (WP_A > HZWE_NS + SD_NS) ? WP_A : HZWE_NS + SD_NS;
	localparam logic [asrc_pkg::ASRC_CNT_W-1:0] WP_CYC = asrc_pkg::asrc_cyc(WP_NS);
	localparam logic [asrc_pkg::ASRC_CNT_W-1:0] CYC_MIN = asrc_pkg::asrc_cyc(
		asrc_pkg::asrc_sel(GRADE, asrc_pkg::ASRC_RC_NS_F, asrc_pkg::ASRC_RC_NS_S));

	// Read data arrives from the pin, so it is resynchronised
	logic [asrc_pkg::ASRC_DW-1:0] bus_sync;
	asrc_sync #(
		.W(asrc_pkg::ASRC_DW)
	) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.din(shared_data_bus_in),
		.dout(bus_sync)
	);

	asrc_pkg::asrc_state_t state;
	asrc_pkg::asrc_state_t next_state;
	logic [asrc_pkg::ASRC_CNT_W-1:0] cnt;
	logic [asrc_pkg::ASRC_CNT_W-1:0] next_cnt;
	logic [asrc_pkg::ASRC_CNT_W-1:0] span;
	logic [asrc_pkg::ASRC_CNT_W-1:0] next_span;
	logic is_write;
	logic [asrc_pkg::ASRC_DW-1:0] wdata;

	localparam logic [asrc_pkg::ASRC_CNT_W-1:0] ASRC_ZERO = '0;
	// Sync latency before read data is trusted
	localparam logic [asrc_pkg::ASRC_CNT_W-1:0] SYNC_CYC = 4'h3;
	// Select and enable fall together, so the slower path sets the wait
	localparam logic [asrc_pkg::ASRC_CNT_W-1:0] ACC_CYC = (RD_CYC > OE_CYC) ? RD_CYC : OE_CYC;
	localparam logic [asrc_pkg::ASRC_CNT_W-1:0] RD_WAIT = ACC_CYC + SYNC_CYC;

	// Phase decodes shared by several pin terms
	function automatic logic rd_phase(input asrc_pkg::asrc_state_t s);
		return (s == asrc_pkg::ASRC_RD_ACC) || (s == asrc_pkg::ASRC_RD_END);
	endfunction

	function automatic logic wr_phase(input asrc_pkg::asrc_state_t s);
		return (s == asrc_pkg::ASRC_WR_PULSE);
	endfunction

	function automatic logic drv_phase(input asrc_pkg::asrc_state_t s);
		return (s == asrc_pkg::ASRC_WR_PULSE) || (s == asrc_pkg::ASRC_WR_END);
	endfunction

	wire cnt_done = (cnt == ASRC_ZERO);
	wire take = req_valid && req_ready;

	// Remaining spacing so that the whole access spans the cycle time
	wire span_met = (span >= CYC_MIN);
	wire [asrc_pkg::ASRC_CNT_W-1:0] rest = span_met ? asrc_pkg::ASRC_CNT_ONE : CYC_MIN - span;

	// Counter parks at zero rather than wrapping
	wire [asrc_pkg::ASRC_CNT_W-1:0] cnt_dec = cnt_done ? cnt : cnt - asrc_pkg::ASRC_CNT_ONE;
	wire [asrc_pkg::ASRC_CNT_W-1:0] span_inc = span + asrc_pkg::ASRC_CNT_ONE;

	assign req_ready = (state == asrc_pkg::ASRC_IDLE);

	always_comb begin
		next_state = state;
		next_cnt = cnt_dec;
		next_span = span_inc;
		case (state)
			asrc_pkg::ASRC_IDLE: begin
				next_span = ASRC_ZERO;
				if (take && req_write) begin
					// Let the memory release the bus before driving it
					next_state = asrc_pkg::ASRC_WR_TURN;
					next_cnt = HZOE_CYC;
				end else if (take) begin
					next_state = asrc_pkg::ASRC_RD_ACC;
					next_cnt = RD_WAIT;
				end
			end
			asrc_pkg::ASRC_RD_ACC: begin
				if (cnt_done) begin
					next_state = asrc_pkg::ASRC_RD_END;
				end
			end
			asrc_pkg::ASRC_RD_END: begin
				next_state = asrc_pkg::ASRC_RECOVER;
				next_cnt = rest;
			end
			asrc_pkg::ASRC_WR_TURN: begin
				if (cnt_done) begin
					next_state = asrc_pkg::ASRC_WR_PULSE;
					next_cnt = WP_CYC;
				end
			end
			asrc_pkg::ASRC_WR_PULSE: begin
				if (cnt_done) begin
					next_state = asrc_pkg::ASRC_WR_END;
				end
			end
			asrc_pkg::ASRC_WR_END: begin
				next_state = asrc_pkg::ASRC_RECOVER;
				next_cnt = rest;
			end
			asrc_pkg::ASRC_RECOVER: begin
				if (cnt_done) begin
					next_state = asrc_pkg::ASRC_IDLE;
				end
			end
			default: begin
				next_state = asrc_pkg::ASRC_IDLE;
				next_cnt = ASRC_ZERO;
			end
		endcase
	end

	// Pin decode, registered below so pins never glitch
	wire next_rd = rd_phase(next_state);
	wire next_wr = wr_phase(next_state);
	wire next_sel = next_rd || next_wr;
	wire next_oe = next_rd;
	// Strobe low only in the pulse; select falls and rises with it, so both end the write together
	wire next_we = next_wr;
	// Data driven from turnaround end through one cycle past the ending edge
	wire next_drv = drv_phase(next_state);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= asrc_pkg::ASRC_IDLE;
			cnt <= '0;
			span <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			span <= next_span;
		end
	end

	// Address and data latched at acceptance only, so they stay put
	// across the whole window
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			word_address <= '0;
			wdata <= '0;
			is_write <= 1'b0;
		end else if (take) begin
			word_address <= req_addr;
			wdata <= req_wdata;
			is_write <= req_write;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			select_n <= 1'b1;
			out_enable_n <= 1'b1;
			write_strobe_n <= 1'b1;
			shared_data_bus_oe <= 1'b0;
			shared_data_bus_out <= '0;
		end else begin
			select_n <= !next_sel;
			out_enable_n <= !next_oe;
			write_strobe_n <= !next_we;
			shared_data_bus_oe <= next_drv;
			shared_data_bus_out <= next_drv ? wdata : '0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end else begin
			rsp_valid <= (state == asrc_pkg::ASRC_RD_END) && !is_write;
			// Sampled only at read end, after the full access and sync wait
			if (state == asrc_pkg::ASRC_RD_END) begin
				rsp_rdata <= bus_sync;
			end
		end
	end
endmodule

// ==== verif/asrc_host_asserts.sv ====
module asrc_host_asserts (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic [asrc_pkg::ASRC_AW-1:0] word_address,
	input wire logic select_n,
	input wire logic out_enable_n,
	input wire logic write_strobe_n,
	input wire logic [asrc_pkg::ASRC_DW-1:0] shared_data_bus_out,
	input wire logic shared_data_bus_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_RD_STROBE_HIGH: assert property (!select_n && !out_enable_n |-> write_strobe_n)
		else $error("strobe low in read");
	AST_NO_CONTENTION: assert property (!out_enable_n |-> !shared_data_bus_oe && $past(!shared_data_bus_oe))
		else $error("bus driven while memory enabled");
	AST_WR_ADDR_HOLD: assert property (!select_n && !write_strobe_n |-> $stable(word_address))
		else $error("address moved in write");
	AST_WR_PULSE: assert property ($fell(write_strobe_n) |-> (!write_strobe_n && !select_n && shared_data_bus_oe)[*3])
		else $error("write pulse short");
	AST_WR_END_JOINT: assert property ($rose(write_strobe_n) |-> $rose(select_n))
		else $error("strobes not ending together");
	AST_WR_DATA_HOLD: assert property ($rose(write_strobe_n) |-> shared_data_bus_oe && $stable(shared_data_bus_out))
		else $error("write data not held");
	AST_RD_ADDR_STABLE: assert property (!select_n && $past(!select_n) && !out_enable_n |-> $stable(word_address))
		else $error("address moved in read");
	AST_RSP_AT_END: assert property (rsp_valid |-> $rose(select_n) && $past(!out_enable_n))
		else $error("response outside read end");
	AST_SPACING: assert property ($rose(select_n) |-> select_n[*2])
		else $error("accesses too close");
	cover property (rsp_valid);
	cover property ($fell(write_strobe_n));
	cover property (req_valid && req_ready ##1 !req_ready);
endmodule

bind asrc_host asrc_host_asserts asrc_host_asserts_u (
	.core_clk(core_clk),
	.rst(rst),
	.req_valid(req_valid),
	.req_ready(req_ready),
	.rsp_valid(rsp_valid),
	.word_address(word_address),
	.select_n(select_n),
	.out_enable_n(out_enable_n),
	.write_strobe_n(write_strobe_n),
	.shared_data_bus_out(shared_data_bus_out),
	.shared_data_bus_oe(shared_data_bus_oe)
);

// ==== verif/asrc_sram_model.sv ====
module asrc_sram_model #(
	parameter int ACC_NS = 55
) (
	input wire logic [14:0] word_address,
	input wire logic select_n,
	input wire logic out_enable_n,
	input wire logic write_strobe_n,
	input wire logic [7:0] bus_level,
	output logic [7:0] dq_drv
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:32767];
	logic [7:0] rd = 8'h00;
	wire drive = !select_n && !out_enable_n && write_strobe_n;
	wire wr_n = select_n | write_strobe_n;
	always @(posedge wr_n) mem[word_address] <= bus_level;
	// Old data lingers until the access delay ends
	always @(word_address, drive) if (drive) rd <= #(ACC_NS) mem[word_address];
	// Released bus shows inverted last value so stale reads fail
	always_comb dq_drv = drive ? rd : ~rd;
endmodule

// ==== verif/asrc_host_bench.sv ====
module asrc_host_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic w; logic [14:0] a; logic [7:0] d;} asrc_row_t;
	// Row data chosen so no expected byte equals the inverted previous read
	localparam asrc_row_t ROWS [6] = '{'{1'b1, 15'h0000, 8'hC3}, '{1'b1, 15'h7FFF, 8'h5A}, '{1'b0, 15'h7FFF, 8'h5A},
		'{1'b0, 15'h0000, 8'hC3}, '{1'b1, 15'h0000, 8'h69}, '{1'b0, 15'h0000, 8'h69}};
	localparam asrc_row_t UNUSED_ROWS [6] = '{'{1'b1, 15'h0000, 8'hA5}, '{1'b1, 15'h7FFF, 8'h5A}, '{1'b0, 15'h7FFF, 8'h5A},
		'{1'b0, 15'h0000, 8'hA5}, '{1'b1, 15'h0000, 8'h69}, '{1'b0, 15'h0000, 8'h69}};
	logic core_clk, rst, req_valid, req_ready, req_write, rsp_valid;
	logic select_n, out_enable_n, write_strobe_n, shared_data_bus_oe;
	logic [14:0] req_addr, word_address;
	logic [7:0] req_wdata, rsp_rdata, shared_data_bus_in, shared_data_bus_out, dq_drv;
	int fail_count = 0;
	int total_checks = 0;
	asrc_host dut_u (
		.core_clk(core_clk),
		.rst(rst),
		.req_valid(req_valid),
		.req_ready(req_ready),
		.req_write(req_write),
		.req_addr(req_addr),
		.req_wdata(req_wdata),
		.rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata),
		.word_address(word_address),
		.select_n(select_n),
		.out_enable_n(out_enable_n),
		.write_strobe_n(write_strobe_n),
		.shared_data_bus_in(shared_data_bus_in),
		.shared_data_bus_out(shared_data_bus_out),
		.shared_data_bus_oe(shared_data_bus_oe)
	);
	asrc_sram_model mem_u (
		.word_address(word_address),
		.select_n(select_n),
		.out_enable_n(out_enable_n),
		.write_strobe_n(write_strobe_n),
		.bus_level(shared_data_bus_in),
		.dq_drv(dq_drv)
	);
	assign shared_data_bus_in = shared_data_bus_oe ? shared_data_bus_out : dq_drv;
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic issue(input logic w, input logic [14:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge core_clk);
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 50) begin
			fail_count++;
		end
		@(negedge core_clk);
		req_valid = 1'b0;
	endtask
	task automatic xfer(input asrc_row_t r, output logic [7:0] q);
		int n;
		n = 0;
		issue(r.w, r.a, r.d);
		q = 8'h00;
		// Bounded wait: a lost response must not hang the run
		while (!r.w && rsp_valid !== 1'b1 && n < 50) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 50) begin
			fail_count++;
		end
		if (!r.w) q = rsp_rdata;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		test_done;
	end
	initial begin
		logic [7:0] q;
		rst = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 15'h0000;
		req_wdata = 8'h00;
		repeat (8) @(negedge core_clk);
		chk({4'h0, select_n, out_enable_n, write_strobe_n, shared_data_bus_oe}, 8'h0E);
		chk({7'h00, req_ready}, 8'h01);
		rst = 1'b0;
		foreach (ROWS[i]) begin
			xfer(ROWS[i], q);
			if (!ROWS[i].w) chk(q, ROWS[i].d);
		end
		issue(1'b1, 15'h0100, 8'hFF);
		repeat (3) @(negedge core_clk);
		chk({6'h00, select_n, write_strobe_n}, 8'h00);
		rst = 1'b1;
		#1;
		chk({4'h0, select_n, out_enable_n, write_strobe_n, shared_data_bus_oe}, 8'h0E);
		@(negedge core_clk);
		rst = 1'b0;
		xfer('{1'b0, 15'h7FFF, 8'h5A}, q);
		chk(q, 8'h5A);
		test_done;
	end
endmodule
